// >>> hdl/ioc_pkg.sv
package ioc_pkg;

	// Word and code widths on the cable group
	localparam int unsigned DATA_W   = 48;
	localparam int unsigned FCODE_W  = 12;

	// Clock rate and strobe duration
	localparam int unsigned CLK_PERIOD_PS = 5000;
	localparam int unsigned STROBE_NS     = 4800;
	localparam int unsigned STROBE_CYC    = (STROBE_NS * 1000) / CLK_PERIOD_PS;
	localparam int unsigned STROBE_CNT_W  = 10;
	localparam logic [STROBE_CNT_W-1:0] STROBE_LAST =
		STROBE_CNT_W'(STROBE_CYC - 1);

	// Output data settle time before output ready rises
	localparam int unsigned SETTLE_CYC   = 2;
	localparam logic [1:0]  SETTLE_LAST  = 2'(SETTLE_CYC - 1);

	// Skid buffer depth
	localparam int unsigned BUF_DEPTH = 2;

	// Strobe kinds
	typedef enum logic [1:0] {
		IOC_IN_FUNC   = 2'b00,
		IOC_IN_SENSE  = 2'b01,
		IOC_OUT_FUNC  = 2'b10,
		IOC_OUT_SENSE = 2'b11
	} ioc_strobe_e;

	// Word handshake states
	typedef enum logic [1:0] {
		IOC_WS_IDLE   = 2'b00,
		IOC_WS_SETTLE = 2'b01,
		IOC_WS_READY  = 2'b10,
		IOC_WS_CLOSE  = 2'b11
	} ioc_wstate_e;

	// Function or sense request
	typedef struct packed {
		ioc_strobe_e          kind;
		logic [FCODE_W-1:0]   code;
	} ioc_freq_s;

	// Strobe lines toward the equipment
	typedef struct packed {
		logic in_func;
		logic in_sense;
		logic out_func;
		logic out_sense;
	} ioc_strobes_s;

endpackage : ioc_pkg

// >>> hdl/ioc_channel.sv
// Overview of operation
// - Master clear held high while requested; equipment resets while it stands.
// - Equipment interrupt level held until cleared; computer diverts to service.
// - Input-function strobe pulses with code, drops after 4.8 us.
// - Input-sense strobe raised with code, drops after 4.8 us.
// - Output-function strobe raised with code, drops after 4.8 us.
// - Output-sense strobe raised with code, drops after 4.8 us.
// - Transfer channel leaves block-active and input strobes unused.
// - Transfer channel: separate 48-bit data sets, one shared control set.
// - Input block: select equipment, then hold input-block-active whole block.
// - After capturing the input word, computer raises input-resume.
// - Input-ready falling makes computer drop input-resume.
// - Repeat input handshakes; drop input-block-active after the last.
// - Output block: raise output-block-active until final word sent.
// - Output word loaded and driven; output-ready only after lines settle.
// - Output-resume high makes computer drop output-ready.
// - Repeat output handshakes; drop output-block-active after the last.
// - Forty-eight input and forty-eight output data lines per group.
`timescale 1ns/1ps
module ioc_channel
	import ioc_pkg::*;
#(
	parameter bit TRANSFER_CH = 1'b0
) (
	// Clock and reset
	input  wire logic                  mclk_i,
	input  wire logic                  rst_n_i,
	// Computer side: clear and interrupt
	input  wire logic                  clear_req_i,
	output logic                       irq_o,
	// Computer side: function and sense requests
	input  wire logic                  freq_valid_i,
	input  ioc_pkg::ioc_freq_s         freq_i,
	output logic                       freq_ready_o,
	output logic                       sense_done_o,
	output logic                       sense_result_o,
	// Computer side: block control
	input  wire logic                  in_blk_start_i,
	input  wire logic                  in_blk_last_i,
	input  wire logic                  out_blk_start_i,
	output logic                       in_blk_busy_o,
	output logic                       out_blk_busy_o,
	// Computer side: input words
	output logic                       in_valid_o,
	input  wire logic                  in_ready_i,
	output logic [ioc_pkg::DATA_W-1:0] in_data_o,
	// Computer side: output words
	input  wire logic                  out_valid_i,
	input  wire logic                  out_last_i,
	output logic                       out_ready_o,
	input  wire logic [ioc_pkg::DATA_W-1:0] out_data_i,
	// Cable: data
	input  wire logic [ioc_pkg::DATA_W-1:0] cab_in_data_i,
	output logic [ioc_pkg::DATA_W-1:0] cab_out_data_o,
	// Cable: handshake
	input  wire logic                  cab_in_ready_i,
	output logic                       cab_in_resume_o,
	output logic                       cab_out_ready_o,
	input  wire logic                  cab_out_resume_i,
	output logic                       cab_in_active_o,
	output logic                       cab_out_active_o,
	// Cable: function, sense, clear, interrupt
	output ioc_pkg::ioc_strobes_s      cab_strobes_o,
	output logic [ioc_pkg::FCODE_W-1:0] cab_fcode_o,
	input  wire logic                  cab_sense_resp_i,
	input  wire logic                  cab_irq_i,
	output logic                       cab_clear_o
);
	import ioc_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Input synchronisers

	localparam int unsigned NSYNC = 4;
	logic [NSYNC-1:0] sync1;
	logic [NSYNC-1:0] sync2;
	logic             s_in_ready;
	logic             s_out_resume;
	logic             s_sense;
	logic             s_irq;

	// Two flops per incoming level; first stage read only by second
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			sync1 <= '0;
			sync2 <= '0;
		end else begin
			sync1 <= {cab_irq_i, cab_sense_resp_i, cab_out_resume_i, cab_in_ready_i};
			sync2 <= sync1;
		end
	end

	assign s_in_ready   = sync2[0];
	assign s_out_resume = sync2[1];
	assign s_sense      = sync2[2];
	assign s_irq        = sync2[3];

	////////////////////////////////////////////////////////////////////////////
	// Clear and interrupt

	// Registered clear keeps the line glitch free
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			cab_clear_o <= 1'b0;
		end else begin
			cab_clear_o <= clear_req_i;
		end
	end

	assign irq_o = s_irq;

	////////////////////////////////////////////////////////////////////////////
	// Function and sense strobes

	// Transfer channel has no input strobes
	function automatic logic kind_allowed(input ioc_strobe_e k);
		kind_allowed = !(TRANSFER_CH && (k == IOC_IN_FUNC || k == IOC_IN_SENSE));
	endfunction : kind_allowed

	logic                    strobe_on;
	ioc_strobe_e             strobe_kind;
	logic [STROBE_CNT_W-1:0] strobe_cnt;
	logic                    resp_seen;
	logic                    freq_take;

	assign freq_ready_o = !strobe_on;
	assign freq_take    = freq_valid_i && !strobe_on && kind_allowed(freq_i.kind);

	// Code and strobe register on one edge, so the code never lags its strobe
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			strobe_on   <= 1'b0;
			strobe_kind <= IOC_IN_FUNC;
			strobe_cnt  <= '0;
			cab_fcode_o <= '0;
		end else if (freq_take) begin
			strobe_on   <= 1'b1;
			strobe_kind <= freq_i.kind;
			strobe_cnt  <= '0;
			cab_fcode_o <= freq_i.code;
		end else if (strobe_on) begin
			strobe_cnt <= strobe_cnt + 1'b1;
			if (strobe_cnt == STROBE_LAST) begin
				strobe_on <= 1'b0;
			end
		end
	end

	// Strobe decode; a refused kind never reaches the wire
	always_comb begin
		cab_strobes_o           = '0;
		cab_strobes_o.in_func   = strobe_on && strobe_kind == IOC_IN_FUNC;
		cab_strobes_o.in_sense  = strobe_on && strobe_kind == IOC_IN_SENSE;
		cab_strobes_o.out_func  = strobe_on && strobe_kind == IOC_OUT_FUNC;
		cab_strobes_o.out_sense = strobe_on && strobe_kind == IOC_OUT_SENSE;
	end

	// Sense answer: any high response seen during the strobe counts
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			resp_seen      <= 1'b0;
			sense_done_o   <= 1'b0;
			sense_result_o <= 1'b0;
		end else begin
			sense_done_o <= 1'b0;
			if (freq_take) begin
				resp_seen <= 1'b0;
			end else if (strobe_on && strobe_kind[0] && s_sense) begin
				resp_seen <= 1'b1;
			end
			if (strobe_on && strobe_kind[0] && strobe_cnt == STROBE_LAST) begin
				sense_done_o   <= 1'b1;
				sense_result_o <= resp_seen || s_sense;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Input block: four-phase word handshake into a two-entry buffer

	logic [DATA_W-1:0] ibuf [BUF_DEPTH];
	logic [1:0]        ib_cnt;
	logic              ib_wp;
	logic              ib_rp;
	logic              ib_push;
	logic              ib_pop;
	logic              in_last_pend;

	assign in_valid_o = ib_cnt != 2'd0;
	assign in_data_o  = ibuf[ib_rp];
	assign ib_pop     = in_valid_o && in_ready_i;
	// Word taken only when room exists; a full buffer stalls the equipment
	assign ib_push    = cab_in_active_o && s_in_ready && !cab_in_resume_o
		&& (ib_cnt != 2'(BUF_DEPTH));

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			ib_cnt <= '0;
			ib_wp  <= 1'b0;
			ib_rp  <= 1'b0;
		end else begin
			if (ib_push) begin
				ib_wp <= !ib_wp;
			end
			if (ib_pop) begin
				ib_rp <= !ib_rp;
			end
			ib_cnt <= ib_cnt + 2'(ib_push) - 2'(ib_pop);
		end
	end

	// Buffer storage; data needs no reset
	always_ff @(posedge mclk_i) begin
		if (ib_push) begin
			ibuf[ib_wp] <= cab_in_data_i;
		end
	end

	// Resume follows capture, clears when ready falls; last word ends block
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			cab_in_resume_o <= 1'b0;
			cab_in_active_o <= 1'b0;
			in_last_pend    <= 1'b0;
		end else begin
			if (in_blk_start_i && !cab_in_active_o && !cab_out_active_o && !TRANSFER_CH) begin
				cab_in_active_o <= 1'b1;
				in_last_pend    <= 1'b0;
			end else if (cab_in_active_o && in_blk_last_i) begin
				in_last_pend <= 1'b1;
			end
			if (ib_push) begin
				cab_in_resume_o <= 1'b1;
			end else if (cab_in_resume_o && !s_in_ready) begin
				cab_in_resume_o <= 1'b0;
				if (in_last_pend || in_blk_last_i) begin
					cab_in_active_o <= 1'b0;
				end
			end
		end
	end

	assign in_blk_busy_o = cab_in_active_o;

	////////////////////////////////////////////////////////////////////////////
	// Output block: settle, ready, resume, close

	ioc_wstate_e wst;
	logic [1:0]  settle_cnt;
	logic        word_last;

	// Block active drops only after the last word's close phase
	assign out_ready_o    = cab_out_active_o && wst == IOC_WS_IDLE;
	assign out_blk_busy_o = cab_out_active_o;

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			wst              <= IOC_WS_IDLE;
			settle_cnt       <= '0;
			word_last        <= 1'b0;
			cab_out_data_o   <= '0;
			cab_out_ready_o  <= 1'b0;
			cab_out_active_o <= 1'b0;
		end else begin
			case (wst)
				IOC_WS_IDLE: begin
					if (out_blk_start_i && !cab_out_active_o && !cab_in_active_o) begin
						cab_out_active_o <= !TRANSFER_CH || 1'b0;
					end
					if (out_valid_i && cab_out_active_o) begin
						cab_out_data_o <= out_data_i;
						word_last      <= out_last_i;
						settle_cnt     <= '0;
						wst            <= IOC_WS_SETTLE;
					end
				end
				IOC_WS_SETTLE: begin
					settle_cnt <= settle_cnt + 1'b1;
					if (settle_cnt == SETTLE_LAST) begin
						cab_out_ready_o <= 1'b1;
						wst             <= IOC_WS_READY;
					end
				end
				IOC_WS_READY: begin
					if (s_out_resume) begin
						cab_out_ready_o <= 1'b0;
						wst             <= IOC_WS_CLOSE;
					end
				end
				IOC_WS_CLOSE: begin
					if (!s_out_resume) begin
						wst <= IOC_WS_IDLE;
						if (word_last) begin
							cab_out_active_o <= 1'b0;
						end
					end
				end
				default: begin
					wst <= IOC_WS_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks

	sequence s_strobe_rise;
		freq_take;
	endsequence

	a_strobe_width: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		s_strobe_rise |=> strobe_on [*8])
		else $error("strobe dropped early");

	a_strobe_drop: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		strobe_on && strobe_cnt == STROBE_LAST |=> !strobe_on)
		else $error("strobe not dropped on time");

	a_strobe_onehot: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		$onehot0(cab_strobes_o))
		else $error("more than one strobe high");

	a_code_stable: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		strobe_on && $past(strobe_on) |-> $stable(cab_fcode_o))
		else $error("code moved under strobe");

	a_resume_drop: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		cab_in_resume_o && !s_in_ready |=> !cab_in_resume_o)
		else $error("input resume stuck");

	a_resume_rise: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		ib_push |=> cab_in_resume_o)
		else $error("no resume after capture");

	a_oready_drop: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		cab_out_ready_o && s_out_resume |=> !cab_out_ready_o)
		else $error("output ready not dropped");

	a_oready_settle: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		$rose(cab_out_ready_o) |-> $stable(cab_out_data_o) && cab_out_active_o)
		else $error("output ready before settle");

	a_clear_follow: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		clear_req_i |=> cab_clear_o)
		else $error("clear not forwarded");

	a_xfer_unused: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		TRANSFER_CH |-> !cab_in_active_o && !cab_strobes_o.in_func
		&& !cab_strobes_o.in_sense)
		else $error("unused transfer line driven");

endmodule : ioc_channel

// >>> tb/ioc_equip_model.sv
`timescale 1ns/1ps
module ioc_equip_model
	import ioc_pkg::*;
(
	// Clock and bench reset
	input  wire logic                       mclk_i,
	input  wire logic                       rst_n_i,
	// Lines from the computer
	input  wire logic                       clear_i,
	input  wire logic                       in_active_i,
	input  wire logic                       in_resume_i,
	input  wire logic                       out_ready_i,
	input  wire logic [ioc_pkg::DATA_W-1:0] out_data_i,
	input  ioc_pkg::ioc_strobes_s           strobes_i,
	input  wire logic [ioc_pkg::FCODE_W-1:0] fcode_i,
	// Lines to the computer
	output logic [ioc_pkg::DATA_W-1:0]      in_data_o,
	output logic                            in_ready_o,
	output logic                            out_resume_o,
	output logic                            sense_resp_o,
	output logic                            irq_o
);
	logic [15:0]               cnt;
	logic [3:0]                on;
	logic [3:0]                wait_c;
	logic [ioc_pkg::FCODE_W-1:0] fsel;
	logic [ioc_pkg::DATA_W-1:0] olog [0:15];

	////////////////////////////////////////////////////////////////////////
	// Input side: offer a word, withdraw it on resume
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i || clear_i) begin
			cnt        <= '0;
			in_ready_o <= 1'b0;
			in_data_o  <= '0;
		end else if (in_ready_o && in_resume_i) begin
			in_ready_o <= 1'b0;
			in_data_o  <= ~in_data_o; // Released lines must not keep the word
			cnt        <= cnt + 16'h1;
		end else if (!in_active_i) begin
			in_ready_o <= 1'b0;
		end else if (!in_resume_i && !in_ready_o) begin
			in_ready_o <= 1'b1;
			in_data_o  <= {cnt, cnt ^ 16'hc3a5, ~cnt};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Output side: slow on some words, prompt on others
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i || clear_i) begin
			out_resume_o <= 1'b0;
			on           <= '0;
			wait_c       <= '0;
		end else if (out_resume_o) begin
			if (!out_ready_i) out_resume_o <= 1'b0;
		end else if (out_ready_i) begin
			wait_c <= wait_c + 4'h1;
			if (wait_c == {on[1:0], 2'b00}) begin
				out_resume_o <= 1'b1;
				olog[on]     <= out_data_i;
				on           <= on + 4'h1;
				wait_c       <= '0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Function code taken only under a function strobe
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i || clear_i) fsel <= '0;
		else if (strobes_i.in_func || strobes_i.out_func) fsel <= fcode_i;
	end

	// Interrupt stands while the selection holds
	assign irq_o = fsel[11];
	// Condition present when code bit 0 is set, only under a sense strobe
	assign sense_resp_o = (strobes_i.in_sense || strobes_i.out_sense) && fcode_i[0];
endmodule : ioc_equip_model

// >>> tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import ioc_pkg::*;

	logic                 mclk = 1'b0;
	logic                 rst_n, clear_req, freq_valid, in_blk_start, in_blk_last;
	logic                 out_blk_start, in_ready, out_valid, out_last, rdy;
	logic                 act_q = 1'b0;
	logic                 irq, freq_ready, sense_done, sense_result, in_busy, out_busy;
	logic                 in_valid, out_ready, cin_ready, cin_resume, cout_ready;
	logic                 cout_resume, cin_active, cout_active, sresp, cirq, cclear;
	logic [DATA_W-1:0]    out_data, in_data, cin_data, cout_data;
	logic [DATA_W-1:0]    words [0:4];
	logic [FCODE_W-1:0]   fcode;
	ioc_freq_s            freq;
	ioc_strobes_s         strb;
	ioc_strobes_s         xstrb;
	logic                 xin_act, xout_act;
	int                   n_mismatch = 0;
	int                   checked = 0;
	int                   nin = 0;
	int                   ovl = 0;
	int                   rvl = 0;
	int                   seed = 32'h33b4bf54;

	// Free-running bench clock
	always #2.5 mclk = ~mclk;

	ioc_channel #(.TRANSFER_CH(1'b0)) dut (
		.mclk_i(mclk), .rst_n_i(rst_n), .clear_req_i(clear_req), .irq_o(irq),
		.freq_valid_i(freq_valid), .freq_i(freq), .freq_ready_o(freq_ready),
		.sense_done_o(sense_done), .sense_result_o(sense_result),
		.in_blk_start_i(in_blk_start), .in_blk_last_i(in_blk_last),
		.out_blk_start_i(out_blk_start), .in_blk_busy_o(in_busy), .out_blk_busy_o(out_busy),
		.in_valid_o(in_valid), .in_ready_i(in_ready), .in_data_o(in_data),
		.out_valid_i(out_valid), .out_last_i(out_last), .out_ready_o(out_ready),
		.out_data_i(out_data), .cab_in_data_i(cin_data), .cab_out_data_o(cout_data),
		.cab_in_ready_i(cin_ready), .cab_in_resume_o(cin_resume), .cab_out_ready_o(cout_ready),
		.cab_out_resume_i(cout_resume), .cab_in_active_o(cin_active),
		.cab_out_active_o(cout_active), .cab_strobes_o(strb), .cab_fcode_o(fcode),
		.cab_sense_resp_i(sresp), .cab_irq_i(cirq), .cab_clear_o(cclear));

	ioc_equip_model u_eq (
		.mclk_i(mclk), .rst_n_i(rst_n), .clear_i(cclear), .in_active_i(cin_active),
		.in_resume_i(cin_resume), .out_ready_i(cout_ready), .out_data_i(cout_data),
		.strobes_i(strb), .fcode_i(fcode), .in_data_o(cin_data), .in_ready_o(cin_ready),
		.out_resume_o(cout_resume), .sense_resp_o(sresp), .irq_o(cirq));

	// Transfer-channel copy on the same stimulus; its unused lines must stay low
	ioc_channel #(.TRANSFER_CH(1'b1)) dut_xfer (
		.mclk_i(mclk), .rst_n_i(rst_n), .clear_req_i(clear_req), .irq_o(),
		.freq_valid_i(freq_valid), .freq_i(freq), .freq_ready_o(), .sense_done_o(),
		.sense_result_o(), .in_blk_start_i(in_blk_start), .in_blk_last_i(in_blk_last),
		.out_blk_start_i(out_blk_start), .in_blk_busy_o(), .out_blk_busy_o(),
		.in_valid_o(), .in_ready_i(in_ready), .in_data_o(), .out_valid_i(out_valid),
		.out_last_i(out_last), .out_ready_o(), .out_data_i(out_data),
		.cab_in_data_i(cin_data), .cab_out_data_o(), .cab_in_ready_i(cin_ready),
		.cab_in_resume_o(), .cab_out_ready_o(), .cab_out_resume_i(cout_resume),
		.cab_in_active_o(xin_act), .cab_out_active_o(xout_act), .cab_strobes_o(xstrb),
		.cab_fcode_o(), .cab_sense_resp_i(sresp), .cab_irq_i(cirq), .cab_clear_o());

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [DATA_W-1:0] seen,
			input logic [DATA_W-1:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic give_verdict;
		$display("Checks %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : give_verdict

	// Word the equipment offers as its k-th
	function automatic logic [DATA_W-1:0] exp_in(input logic [15:0] k);
		return {k, k ^ 16'hc3a5, ~k};
	endfunction : exp_in

	// One strobe: count its width, catch the sense answer
	task automatic do_strobe(input ioc_strobe_e k, input logic [FCODE_W-1:0] c);
		int   n;
		int   nd;
		logic res;
		logic [3:0] exp_s;
		n = 0;
		nd = 0;
		res = 1'b0;
		exp_s = 4'b1000 >> k;
		freq.kind = k;
		freq.code = c;
		freq_valid = 1'b1;
		// Ready judged where settled; the next rising edge takes the request once
		while (freq_ready !== 1'b1) @(negedge mclk);
		@(negedge mclk);
		freq_valid = 1'b0;
		repeat (STROBE_CYC + 4) begin
			if (strb === exp_s && fcode === c) n++;
			if (sense_done === 1'b1) begin
				nd++;
				res = sense_result;
			end
			@(negedge mclk);
		end
		chk("strobe cycles", 48'(n), 48'(STROBE_CYC));
		chk("sense done", 48'(nd), 48'(k[0]));
		chk("sense result", 48'(res), 48'(k[0] & c[0]));
	endtask : do_strobe

	////////////////////////////////////////////////////////////////////////
	// Cable watch: overlapping blocks and late handshake drops
	always @(negedge mclk) begin
		if (cin_active === 1'b1 && cout_active === 1'b1) chk("one block", 48'h1, 48'h0);
		if (act_q === 1'b1 && cin_active === 1'b0) chk("ready at end", 48'(cin_ready), 48'h0);
		act_q = cin_active;
		ovl = (cout_ready === 1'b1 && cout_resume === 1'b1) ? ovl + 1 : 0;
		if (ovl == 5) chk("out ready drop", 48'h1, 48'h0);
		rvl = (cin_resume === 1'b1 && cin_ready === 1'b0) ? rvl + 1 : 0;
		if (rvl == 5) chk("in resume drop", 48'h1, 48'h0);
		if (xin_act !== 1'b0 || xout_act !== 1'b0 || xstrb.in_func !== 1'b0
				|| xstrb.in_sense !== 1'b0) chk("xfer unused", 48'h1, 48'h0);
	end

	// Cut a hang short
	initial begin
		repeat (20000) @(posedge mclk);
		n_mismatch++;
		give_verdict();
	end

	////////////////////////////////////////////////////////////////////////
	initial begin
		{rst_n, clear_req, freq_valid, in_blk_start, in_blk_last} = '0;
		{out_blk_start, in_ready, out_valid, out_last} = '0;
		out_data = '0;
		freq = '0;
		repeat (16) @(posedge mclk);
		@(negedge mclk);
		rst_n = 1'b1;
		// Every strobe kind, with the condition absent then present
		for (int k = 0; k < 8; k++) do_strobe(ioc_strobe_e'(k[1:0]), {11'($random(seed)), k[2]});
		// Input block; stall until the buffer refuses
		in_blk_start = 1'b1;
		@(negedge mclk);
		in_blk_start = 1'b0;
		chk("in active", 48'(cin_active), 48'h1);
		repeat (40) @(negedge mclk);
		chk("held word", 48'({cin_ready, cin_resume}), 48'h2);
		chk("buffered", 48'(u_eq.cnt), 48'h2);
		in_blk_last = 1'b1;
		repeat (300) begin
			rdy = 1'($random(seed));
			if (rdy && in_valid === 1'b1) begin
				chk("in word", in_data, exp_in(16'(nin)));
				nin++;
			end
			in_ready = rdy;
			@(negedge mclk);
		end
		// Two buffered words plus the one held back by the full buffer
		chk("in words", 48'(nin), 48'h3);
		chk("equip words", 48'(u_eq.cnt), 48'h3);
		chk("in busy", 48'({in_busy, cin_active}), 48'h0);
		in_blk_last = 1'b0;
		// Output block of five random words
		out_blk_start = 1'b1;
		@(negedge mclk);
		out_blk_start = 1'b0;
		chk("out active", 48'(cout_active), 48'h1);
		for (int i = 0; i < 5; i++) begin
			words[i] = {16'($random(seed)), 32'($random(seed))};
			out_data = words[i];
			out_last = (i == 4);
			out_valid = 1'b1;
			while (out_ready !== 1'b1) @(negedge mclk);
			@(negedge mclk);
		end
		out_valid = 1'b0;
		repeat (200) @(negedge mclk);
		for (int i = 0; i < 5; i++) chk("out word", u_eq.olog[i], words[i]);
		chk("out count", 48'(u_eq.on), 48'h5);
		chk("out busy", 48'({out_busy, cout_active}), 48'h0);
		// Interrupt selection, then master clear
		do_strobe(IOC_OUT_FUNC, 12'h001);
		chk("irq off", 48'(irq), 48'h0);
		do_strobe(IOC_OUT_FUNC, 12'h800);
		chk("irq", 48'(irq), 48'h1);
		clear_req = 1'b1;
		repeat (4) @(negedge mclk);
		chk("clear line", 48'(cclear), 48'h1);
		clear_req = 1'b0;
		repeat (4) @(negedge mclk);
		chk("irq after clear", 48'({irq, cclear}), 48'h0);
		give_verdict();
	end
endmodule : tb_top
